// ### verilog/eisl_pkg.sv
package eisl_pkg;

  // ---------------------------------------------------------------------------
  // Bus and sizes
  // ---------------------------------------------------------------------------
  localparam int EISL_NPIN = 3;
  localparam int EISL_AW = 4;
  localparam int EISL_DW = 32;
  localparam int EISL_LVL_W = 3;
  localparam int EISL_LAT_W = 3;

  // ---------------------------------------------------------------------------
  // Register word indices, byte address is index times four
  // ---------------------------------------------------------------------------
  localparam logic [EISL_AW-1:0] EISL_REG_CTRL0 = 4'h0;
  localparam logic [EISL_AW-1:0] EISL_REG_CTRL1 = 4'h1;
  localparam logic [EISL_AW-1:0] EISL_REG_CTRL2 = 4'h2;
  localparam logic [EISL_AW-1:0] EISL_REG_GLOBAL = 4'h3;
  localparam logic [EISL_AW-1:0] EISL_REG_STATUS = 4'h4;
  localparam logic [EISL_AW-1:0] EISL_REG_MASK = 4'h5;
  localparam logic [EISL_AW-1:0] EISL_REG_PEND = 4'h6;

  // ---------------------------------------------------------------------------
  // Control register fields (per pin)
  // ---------------------------------------------------------------------------
  localparam int EISL_F_LVL_LO = 0;
  localparam int EISL_F_LVL_HI = 2;
  localparam int EISL_F_REQ = 3;
  localparam int EISL_F_POL = 4;
  localparam int EISL_F_SENSE = 5;
  // Global register fields
  localparam int EISL_F_DET_LO = 4;
  localparam int EISL_F_DET_HI = 5;
  localparam int EISL_F_KEY = 7;
  // Accept field position in the pending register; unused, accepts arrive only on irq_accept
  localparam int EISL_F_ACK_LO = 0;

  // ---------------------------------------------------------------------------
  // Detection time settings and latencies in phi cycles
  // ---------------------------------------------------------------------------
  localparam logic [1:0] EISL_DET_SLOW = 2'h0;
  localparam logic [1:0] EISL_DET_MID = 2'h1;
  localparam logic [1:0] EISL_DET_FAST = 2'h2;
  localparam logic [EISL_LAT_W-1:0] EISL_LAT_SLOW = 3'h7;
  localparam logic [EISL_LAT_W-1:0] EISL_LAT_MID = 3'h4;
  localparam logic [EISL_LAT_W-1:0] EISL_LAT_FAST = 3'h2;

  localparam logic [EISL_LVL_W-1:0] EISL_LVL_RST = 3'h0;
  localparam logic [EISL_DW-1:0] EISL_RD_ZERO = 32'h0;

endpackage : eisl_pkg

// ### verilog/eisl_sync.sv
`timescale 1ns/1ps
module eisl_sync
  import eisl_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic pin_async,
  output logic pin_sync,
  output logic pin_prev
);
  logic stage1;

  // ---------------------------------------------------------------------------
  // Two-flop synchroniser plus one sample of history for edge detection
  // ---------------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!nrst) begin
      stage1 <= 1'b1;
      pin_sync <= 1'b1;
      pin_prev <= 1'b1;
    end else begin
      stage1 <= pin_async; // [RULE18]
      pin_sync <= stage1;
      pin_prev <= pin_sync; // [RULE18]
    end
  end
endmodule : eisl_sync

// ### verilog/eisl_lvl_delay.sv
`timescale 1ns/1ps
module eisl_lvl_delay
  import eisl_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic wr,
  input wire logic [EISL_LVL_W-1:0] wdata,
  input wire logic [1:0] det_sel,
  output logic [EISL_LVL_W-1:0] level
);
  logic [EISL_LVL_W-1:0] staged;
  logic [EISL_LAT_W-1:0] count;
  logic [EISL_LAT_W-1:0] lat;

  // ---------------------------------------------------------------------------
  // Latency chosen by detection time; prohibited setting acts as slowest
  // ---------------------------------------------------------------------------
  assign lat = (det_sel == EISL_DET_FAST) ? EISL_LAT_FAST :
               (det_sel == EISL_DET_MID) ? EISL_LAT_MID : EISL_LAT_SLOW; // [RULE11]

  always_ff @(posedge clk) begin
    if (!nrst) begin
      staged <= EISL_LVL_RST;
      count <= '0;
      level <= EISL_LVL_RST;
    end else if (wr) begin
      staged <= wdata;
      count <= lat - 3'h1; // [RULE10]
    end else if (count != '0) begin
      count <= count - 3'h1;
      if (count == 3'h1) begin
        level <= staged; // [RULE10]
      end
    end
  end
endmodule : eisl_lvl_delay

// ### verilog/eisl_top.sv
// Contract
// [RULE1] Sense bit 0 selects edge detection for that pin.
// [RULE2] In edge mode the request flag acts like an internal source flag.
// [RULE3] A detected edge sets the flag, held until the CPU accepts it.
// [RULE4] Software writing 0 to the flag withdraws a pending edge request.
// [RULE5] Software writing 1 to the flag raises a request like an edge.
// [RULE6] Sense bit 1 selects level sense; the flag is then ignored.
// [RULE7] Level mode re-requests after each accept while the pin stays active.
// [RULE8] Level mode drops an unaccepted request once the pin goes inactive.
// [RULE9] Polarity bit picks the active level; the other level is inactive.
// [RULE10] A priority level write takes two to seven cycles to become effective.
// [RULE11] Detection time 00, 01, 10 give 7, 4, 2 cycles; 11 prohibited.
// [RULE12] Software spaces repeated level writes by 4, 2 or 1 fillers.
// [RULE13] Fillers match the no-op cycle count and avoid control writes.
// [RULE14] Software should prefer detection setting 10, the two-cycle latency.
// [RULE15] Condition 00 fall, 01 rise, 10 high level, 11 low level.
// [RULE16] Key-input select bit 1 disables the third pin's interrupt.
// [RULE17] Pins are sampled always; level 0 keeps an unused pin quiet.
// [RULE18] Pins are synchronised; edges compare current and previous samples.
//
// The placing of the registers and the Avalon-MM interface to the registers are this design's own decisions.
`timescale 1ns/1ps
module eisl_top
  import eisl_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic [EISL_AW-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [EISL_DW-1:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [EISL_DW-1:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic [EISL_NPIN-1:0] ext_irq_pin,
  input wire logic [EISL_NPIN-1:0] irq_accept,
  output logic [EISL_NPIN-1:0] irq_request,
  output logic [EISL_NPIN*EISL_LVL_W-1:0] irq_level,
  output logic irq
);

  // ---------------------------------------------------------------------------
  // Bus decode
  // ---------------------------------------------------------------------------
  logic ack;
  logic [1:0] det_sel;
  logic key_sel;
  logic [EISL_NPIN-1:0] sense;
  logic [EISL_NPIN-1:0] pol;
  logic [EISL_NPIN-1:0] flag;
  logic [EISL_NPIN*EISL_LVL_W-1:0] lvl_reg;
  logic [EISL_NPIN-1:0] status;
  logic [EISL_NPIN-1:0] mask;
  logic [EISL_NPIN-1:0] sync_now;
  logic [EISL_NPIN-1:0] sync_prev;
  logic [EISL_NPIN-1:0] request;
  logic [EISL_NPIN-1:0] lvl_wr;
  logic [EISL_NPIN-1:0] ctrl_wr;
  logic [EISL_NPIN*EISL_LVL_W-1:0] eff_level;
  wire bus_req = (avs_read || avs_write) && !ack;
  // Write lands at the edge where the master sees waitrequest low
  wire do_wr = avs_write && ack;
  wire be0 = avs_byteenable[0];
  wire glob_wr = do_wr && be0 && (avs_address == EISL_REG_GLOBAL);
  wire stat_wr = do_wr && be0 && (avs_address == EISL_REG_STATUS);
  wire mask_wr = do_wr && be0 && (avs_address == EISL_REG_MASK);
  logic [EISL_DW-1:0] rd_mux;

  // ---------------------------------------------------------------------------
  // Per-pin logic
  // ---------------------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < EISL_NPIN; g++) begin : g_pin
      logic [EISL_DW-1:0] ctrl_word;
      logic active;
      logic edge_hit;
      logic enabled;
      logic lvl_nz;
      logic sw_wr_flag;
      logic next_flag;
      logic [EISL_LVL_W-1:0] my_lvl;
      eisl_sync u_sync (
        .clk(clk),
        .nrst(nrst),
        .pin_async(ext_irq_pin[g]),
        .pin_sync(sync_now[g]),
        .pin_prev(sync_prev[g])
      );
      assign ctrl_wr[g] = do_wr && be0 && (avs_address == EISL_AW'(g));
      assign lvl_wr[g] = ctrl_wr[g];
      eisl_lvl_delay u_dly (
        .clk(clk),
        .nrst(nrst),
        .wr(lvl_wr[g]),
        .wdata(avs_writedata[EISL_F_LVL_HI:EISL_F_LVL_LO]),
        .det_sel(det_sel),
        .level(my_lvl)
      );
      assign eff_level[g*EISL_LVL_W +: EISL_LVL_W] = my_lvl;
      // Polarity 0 means falling edge or high level, 1 rising edge or low level
      assign active = sense[g] ? (sync_now[g] ^ pol[g]) : (sync_now[g] ^ ~pol[g]); // [RULE9] [RULE15]
      assign edge_hit = !sense[g] && active &&
                        (sense[g] ? 1'b0 : (sync_prev[g] ^ sync_now[g])); // [RULE1] [RULE18]
      assign enabled = !((g == EISL_NPIN - 1) && key_sel); // [RULE16]
      assign lvl_nz = (my_lvl != EISL_LVL_RST); // [RULE17]
      assign sw_wr_flag = ctrl_wr[g];
      // Edge event wins over accept; software write sets or clears directly
      assign next_flag = sw_wr_flag ? avs_writedata[EISL_F_REQ] :  // [RULE4] [RULE5]
                         edge_hit ? 1'b1 :                         // [RULE3]
                         irq_accept[g] ? 1'b0 : flag[g];           // [RULE2]
      // Level mode: request follows the pin, so nothing is held once inactive
      assign request[g] = enabled && lvl_nz &&
                          (sense[g] ? active : flag[g]); // [RULE6] [RULE7] [RULE8]
      always_ff @(posedge clk) begin
        if (!nrst) begin
          flag[g] <= 1'b0;
          pol[g] <= 1'b0;
          sense[g] <= 1'b0;
          lvl_reg[g*EISL_LVL_W +: EISL_LVL_W] <= EISL_LVL_RST;
        end else begin
          flag[g] <= next_flag;
          if (ctrl_wr[g]) begin
            pol[g] <= avs_writedata[EISL_F_POL];
            sense[g] <= avs_writedata[EISL_F_SENSE];
            lvl_reg[g*EISL_LVL_W +: EISL_LVL_W] <= avs_writedata[EISL_F_LVL_HI:EISL_F_LVL_LO];
          end
        end
      end
      always_comb begin
        ctrl_word = EISL_RD_ZERO;
        ctrl_word[EISL_F_LVL_HI:EISL_F_LVL_LO] = lvl_reg[g*EISL_LVL_W +: EISL_LVL_W];
        ctrl_word[EISL_F_REQ] = flag[g];
        ctrl_word[EISL_F_POL] = pol[g];
        ctrl_word[EISL_F_SENSE] = sense[g];
      end
    end
  endgenerate

  // ---------------------------------------------------------------------------
  // Global settings, interrupt status and mask
  // ---------------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!nrst) begin
      det_sel <= EISL_DET_SLOW;
      key_sel <= 1'b0;
      mask <= '0;
      status <= '0;
    end else begin
      if (glob_wr) begin
        det_sel <= avs_writedata[EISL_F_DET_HI:EISL_F_DET_LO]; // [RULE11]
        key_sel <= avs_writedata[EISL_F_KEY];
      end
      if (mask_wr) begin
        mask <= avs_writedata[EISL_NPIN-1:0];
      end
      // New requests set sticky bits; set wins over write-one-to-clear
      status <= (status & ~(stat_wr ? avs_writedata[EISL_NPIN-1:0] : '0)) | request;
    end
  end

  // ---------------------------------------------------------------------------
  // Read mux
  // ---------------------------------------------------------------------------
  always_comb begin
    rd_mux = EISL_RD_ZERO;
    unique case (avs_address)
      EISL_REG_CTRL0: rd_mux = g_pin[0].ctrl_word;
      EISL_REG_CTRL1: rd_mux = g_pin[1].ctrl_word;
      EISL_REG_CTRL2: rd_mux = g_pin[2].ctrl_word;
      EISL_REG_GLOBAL: begin
        rd_mux[EISL_F_DET_HI:EISL_F_DET_LO] = det_sel;
        rd_mux[EISL_F_KEY] = key_sel;
      end
      EISL_REG_STATUS: rd_mux[EISL_NPIN-1:0] = status;
      EISL_REG_MASK: rd_mux[EISL_NPIN-1:0] = mask;
      EISL_REG_PEND: rd_mux[EISL_NPIN-1:0] = request;
      default: rd_mux = EISL_RD_ZERO;
    endcase
  end

  // ---------------------------------------------------------------------------
  // Bus answer: one wait cycle, then ack; outputs registered
  // ---------------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!nrst) begin
      ack <= 1'b0;
      avs_waitrequest <= 1'b1;
      avs_readdata <= EISL_RD_ZERO;
      irq_request <= '0;
      irq_level <= '0;
      irq <= 1'b0;
    end else begin
      ack <= bus_req;
      avs_waitrequest <= !bus_req;
      if (bus_req && avs_read) begin
        avs_readdata <= rd_mux;
      end
      irq_request <= request;
      irq_level <= eff_level; // [RULE10]
      irq <= |(status & mask);
    end
  end

endmodule : eisl_top

// ### dv/eisl_checker.sv
`timescale 1ns/1ps
module eisl_checker
  import eisl_pkg::*;
(
  input logic clk,
  input logic nrst,
  input logic [EISL_AW-1:0] avs_address,
  input logic avs_read,
  input logic avs_write,
  input logic [EISL_DW-1:0] avs_readdata,
  input logic avs_waitrequest,
  input logic [EISL_NPIN-1:0] irq_request,
  input logic [EISL_NPIN*EISL_LVL_W-1:0] irq_level,
  input logic irq
);
  // ---------------------------------------------------------------------------
  // Cycles since the last control register write was taken
  // ---------------------------------------------------------------------------
  logic [3:0] since_wr;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  always_ff @(posedge clk) begin
    if (!nrst) begin
      since_wr <= 4'hF;
    end else if (avs_write && !avs_waitrequest && avs_address <= EISL_REG_CTRL2) begin
      since_wr <= 4'h0;
    end else if (since_wr != 4'hF) begin
      since_wr <= since_wr + 4'h1;
    end
  end
  wr_answer_a: assert property (avs_write && avs_waitrequest |=> !avs_waitrequest)
    else $error("write not answered after one wait cycle");
  rd_answer_a: assert property (avs_read && avs_waitrequest |=> !avs_waitrequest)
    else $error("read not answered after one wait cycle");
  wait_pulse_a: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low for more than one cycle");
  wait_idle_a: assert property (!avs_read && !avs_write |-> avs_waitrequest)
    else $error("waitrequest low while idle");
  rd_zero_a: assert property (avs_read && !avs_waitrequest && avs_address > EISL_REG_PEND
    |-> avs_readdata == EISL_RD_ZERO)
    else $error("unmapped read not zero");
  rd_hold_a: assert property (!avs_read |=> $stable(avs_readdata))
    else $error("read data changed without a read");
  lvl_lat_a: assert property ($changed(irq_level) |-> since_wr inside {[4'h2:4'h7]})
    else $error("priority level changed outside its latency window");
  zero_quiet0_a: assert property ((irq_level[2:0] == 3'h0) [*3] |-> !irq_request[0])
    else $error("pin 0 requests at level zero");
  zero_quiet1_a: assert property ((irq_level[5:3] == 3'h0) [*3] |-> !irq_request[1])
    else $error("pin 1 requests at level zero");
  zero_quiet2_a: assert property ((irq_level[8:6] == 3'h0) [*3] |-> !irq_request[2])
    else $error("pin 2 requests at level zero");
  cover property (avs_write && !avs_waitrequest);
  cover property ($rose(irq));
  cover property ($rose(irq_request[2]));
endmodule : eisl_checker

bind eisl_top eisl_checker chk (.clk, .nrst, .avs_address, .avs_read, .avs_write,
  .avs_readdata, .avs_waitrequest, .irq_request, .irq_level, .irq);

// ### dv/eisl_pin_src.sv
`timescale 1ns/1ps
module eisl_pin_src
  import eisl_pkg::*;
(
  input logic clk,
  output logic [EISL_NPIN-1:0] pins
);
  initial pins = 3'h7;
  // Each level is held six cycles, longer than the pin's minimum width
  task automatic drive(input int i, input logic v);
    @(posedge clk);
    pins[i] <= v;
    repeat (6) @(posedge clk);
  endtask : drive
endmodule : eisl_pin_src

// ### dv/testbench.sv
`timescale 1ns/1ps
module testbench
  import eisl_pkg::*;
;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic [EISL_AW-1:0] avs_address = '0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [EISL_DW-1:0] avs_writedata = '0;
  logic [3:0] avs_byteenable = 4'hF;
  logic [EISL_DW-1:0] avs_readdata;
  logic avs_waitrequest;
  logic [EISL_NPIN-1:0] ext_irq_pin;
  logic [EISL_NPIN-1:0] irq_accept = '0;
  logic [EISL_NPIN-1:0] irq_request;
  logic [EISL_NPIN*EISL_LVL_W-1:0] irq_level;
  logic irq;
  int bad_count = 0;
  int compares = 0;
  int cycles = 0;
  logic [EISL_DW-1:0] notes[$];
  always #25 clk = ~clk;
  eisl_top uut (.clk, .nrst, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_byteenable, .avs_readdata, .avs_waitrequest, .ext_irq_pin, .irq_accept,
    .irq_request, .irq_level, .irq);
  eisl_pin_src src (.clk, .pins(ext_irq_pin));
  // ---------------------------------------------------------------------------
  // Bus tasks, compare and read monitor
  // ---------------------------------------------------------------------------
  task automatic chk(input logic [EISL_DW-1:0] got, input logic [EISL_DW-1:0] exp);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic bus(input logic rw, input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= rw;
    avs_read <= !rw;
    do @(posedge clk); while (avs_waitrequest !== 1'b0);
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask : bus
  task automatic rd(input logic [3:0] a, input logic [31:0] e);
    repeat (3) @(posedge clk);
    notes.push_back(e);
    bus(1'b0, a, 32'h0);
  endtask : rd
  task automatic accept(input logic [2:0] m);
    @(posedge clk);
    irq_accept <= m;
    @(posedge clk);
    irq_accept <= 3'h0;
  endtask : accept
  task automatic lat(input logic [1:0] det, input int want);
    logic [2:0] lv;
    int n;
    lv = irq_level[5:3] ^ 3'($urandom_range(1, 7));
    bus(1'b1, EISL_REG_GLOBAL, {26'h0, det, 4'h0});
    bus(1'b1, EISL_REG_CTRL1, {29'h0, lv});
    n = 0;
    while (irq_level[5:3] !== lv && n < 20) begin
      @(posedge clk);
      n++;
    end
    chk(32'(n == want + 1), 32'h1);
    repeat (2) @(posedge clk);
  endtask : lat
  task automatic tally_and_finish();
    $display("mismatches %0d compares %0d", bad_count, compares);
    if (bad_count == 0 && compares > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : tally_and_finish
  always @(posedge clk) begin
    cycles++;
    if (avs_read && !avs_waitrequest) chk(avs_readdata, notes.pop_front());
    if (cycles == 5000) begin
      bad_count++;
      tally_and_finish();
    end
  end
  initial begin
    void'($urandom(32'h89A330F2));
    repeat (16) @(posedge clk);
    nrst <= 1'b1;
    for (int i = 0; i < 7; i++) rd(4'(i), 32'h0);
    rd(4'hF, 32'h0);
    lat(EISL_DET_SLOW, 7);
    lat(EISL_DET_MID, 4);
    lat(EISL_DET_FAST, 2);
    bus(1'b1, EISL_REG_CTRL0, 32'h5);
    src.drive(0, 1'b0);
    rd(EISL_REG_PEND, 32'h1);
    src.drive(0, 1'b1);
    rd(EISL_REG_PEND, 32'h1);
    bus(1'b1, EISL_REG_MASK, 32'h1);
    repeat (3) @(posedge clk);
    chk(32'(irq), 32'h1);
    accept(3'h1);
    rd(EISL_REG_PEND, 32'h0);
    chk(32'(irq), 32'h1);
    bus(1'b1, EISL_REG_STATUS, 32'h1);
    repeat (3) @(posedge clk);
    chk(32'(irq), 32'h0);
    bus(1'b1, EISL_REG_CTRL0, 32'hD);
    rd(EISL_REG_PEND, 32'h1);
    bus(1'b1, EISL_REG_CTRL0, 32'h5);
    rd(EISL_REG_PEND, 32'h0);
    src.drive(1, 1'b0);
    bus(1'b1, EISL_REG_CTRL1, 32'h15);
    src.drive(1, 1'b1);
    rd(EISL_REG_PEND, 32'h2);
    accept(3'h2);
    bus(1'b1, EISL_REG_CTRL2, 32'h2B);
    rd(EISL_REG_PEND, 32'h4);
    accept(3'h4);
    rd(EISL_REG_PEND, 32'h4);
    chk(32'(irq_request), 32'h4);
    src.drive(2, 1'b0);
    rd(EISL_REG_PEND, 32'h0);
    bus(1'b1, EISL_REG_CTRL2, 32'h33);
    rd(EISL_REG_PEND, 32'h4);
    bus(1'b1, EISL_REG_GLOBAL, 32'hA0);
    rd(EISL_REG_PEND, 32'h0);
    bus(1'b1, EISL_REG_CTRL0, 32'h8);
    rd(EISL_REG_PEND, 32'h0);
    repeat (4) @(posedge clk);
    tally_and_finish();
  end
endmodule : testbench
